/* rtl/cbpwc_core.sv */
// Power, wake and system interrupt control of a dual card bridge
`timescale 1ns/1ps
module cbpwc_core (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic                    clk_en,
  // Configuration
  input  wire logic                    interrupt_tie,
  input  wire logic                    mode_wr,
  input  wire cbpwc_pkg::cbpwc_mode_e  mode_in,
  input  wire logic                    system_mgmt_int_route,
  input  wire logic                    system_mgmt_int_enable,
  input  wire logic                    change_irq_mode,
  input  wire logic [2:0]              irq2_pin_sel,
  input  wire logic                    hold_clock_request,
  input  wire logic [1:0]              pmstate_wr,
  input  wire cbpwc_pkg::cbpwc_pstate_e pmstate_in,
  // Per socket control, bit n is socket n
  input  wire logic [1:0]              power_change_wr,
  input  wire logic [1:0]              smi_pending_clr,
  input  wire logic [1:0]              card_output_enable,
  input  wire logic [1:0]              auto_power_down,
  input  wire logic [1:0]              ring_enable,
  input  wire logic [1:0]              status_change_mask,
  input  wire logic [1:0]              card_is_16bit,
  input  wire logic [1:0]              card_powered,
  input  wire logic [1:0]              card_activity,
  input  wire logic [1:0]              csc_event,
  input  wire logic [1:0]              func_int,
  // Busy sources
  input  wire logic                    res16_busy,
  input  wire logic                    cb_master_busy,
  input  wire logic                    pci_master_busy,
  // Card and host pins, from outside the clock domain
  input  wire logic [1:0]              card_int_request,
  input  wire logic [1:0]              cardbus_int,
  input  wire logic [1:0]              card_status_change,
  input  wire logic [1:0]              ring_indicate_in,
  input  wire logic [1:0]              card_clock_run_in,
  input  wire logic [1:0]              cardbus_bus_request,
  input  wire logic [1:0]              dma_request,
  input  wire logic                    suspend,
  input  wire logic                    pci_reset_in,
  input  wire logic                    pci_clock_run_in,
  // Status outputs
  output logic [7:0]                   int_pin_value_f0,
  output logic [7:0]                   int_pin_value_f1,
  output cbpwc_pkg::cbpwc_mode_e       mode,
  output logic [1:0]                   system_mgmt_int_pending,
  output cbpwc_pkg::cbpwc_pstate_e     pmstate_f0,
  output cbpwc_pkg::cbpwc_pstate_e     pmstate_f1,
  // Interrupt outputs
  output logic [1:0]                   csc_int,
  output logic                         inta_mf0,
  output logic                         intb_mf1,
  output logic                         irq2_mf3_n,
  output logic                         irq2_mf6_n,
  output logic                         serial_irq_line_o,
  output logic                         serial_irq_line_oe,
  // Clock run and card clock
  output logic                         pci_clock_run_o,
  output logic                         pci_clock_run_oe,
  output logic [1:0]                   card_clock_en,
  output logic [1:0]                   card_clock_run_o,
  output logic [1:0]                   card_clock_run_oe,
  // Card interface power and suspend
  output logic [1:0]                   card_if_tristate,
  output logic [1:0]                   card_reset,
  output logic                         core_reset_gated,
  output logic                         core_clock_gate,
  output logic                         ring_wake_out
);
  import cbpwc_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers: three stages, change taken when 2 and 3 agree
  // ----------------------------------------------------------------
  localparam int unsigned NPIN = 16;
  logic [NPIN-1:0] pin_raw, s1, s2, s3, pin_q, next_pin_q;
  assign pin_raw = {pci_clock_run_in, pci_reset_in, suspend,
                    card_clock_run_in, dma_request, cardbus_bus_request,
                    card_status_change, cardbus_int, card_int_request,
                    1'b0};
  always_comb begin
    next_pin_q = pin_q;
    for (int i = 0; i < NPIN; i++) begin
      if (s2[i] == s3[i]) begin
        next_pin_q[i] = s3[i];
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1    <= '0;
      s2    <= '0;
      s3    <= '0;
      pin_q <= '0;
    end else if (clk_en) begin
      s1    <= pin_raw;
      s2    <= s1;
      s3    <= s2;
      pin_q <= next_pin_q;
    end
  end
  logic [1:0] card_int_request_s, cardbus_int_s, csts_s, card_clock_run_s, cardbus_bus_request_s, dma_request_s;
  logic       susp_s, pci_reset_in_s, pci_clock_run_s;
  assign card_int_request_s    = pin_q[2:1];
  assign cardbus_int_s    = pin_q[4:3];
  assign csts_s    = pin_q[6:5];
  assign cardbus_bus_request_s    = pin_q[8:7];
  assign dma_request_s    = pin_q[10:9];
  assign card_clock_run_s = pin_q[12:11];
  assign susp_s    = pin_q[13];
  assign pci_reset_in_s    = pin_q[14];
  assign pci_clock_run_s  = pin_q[15];

  // ----------------------------------------------------------------
  // Mode, power states, management interrupt pending
  // ----------------------------------------------------------------
  cbpwc_mode_e   next_mode;
  cbpwc_pstate_e next_pm0, next_pm1;
  logic [1:0]    next_pend, pend_d, next_pend_d;
  always_comb begin
    next_mode = mode;
    next_pm0  = pmstate_f0;
    next_pm1  = pmstate_f1;
    if (mode_wr) begin
      next_mode = mode_in;
    end
    if (pmstate_wr[0]) begin
      next_pm0 = pmstate_in;
    end
    if (pmstate_wr[1]) begin
      next_pm1 = pmstate_in;
    end
    // Set beats a write-one clear in the same cycle
    next_pend = (system_mgmt_int_pending & ~smi_pending_clr)
              | ({2{system_mgmt_int_enable}} & power_change_wr);
    next_pend_d = system_mgmt_int_pending;
  end

  // ----------------------------------------------------------------
  // Interrupt delivery
  // ----------------------------------------------------------------
  logic [1:0] smi_csc, smi_edge, next_csc;
  logic       smi_irq2, any_int, next_inta, next_intb;
  logic       next_irq2_3, next_irq2_6;
  logic [7:0] next_pin1;
  always_comb begin
    smi_edge = system_mgmt_int_pending & ~pend_d;
    smi_csc  = change_irq_mode ? system_mgmt_int_pending : smi_edge;
    smi_irq2 = system_mgmt_int_route & (|system_mgmt_int_pending);
    next_csc = csc_event | (system_mgmt_int_route ? 2'b00 : smi_csc);
    if (interrupt_tie) begin
      next_inta = |func_int;
      next_intb = 1'b0;
      next_pin1 = CBPWC_PIN_A;
    end else begin
      next_inta = func_int[0];
      next_intb = func_int[1];
      next_pin1 = CBPWC_PIN_B;
    end
    next_irq2_3 = !(smi_irq2 && mode == CBPWC_MODE_PAR_IRQ
                   && irq2_pin_sel == CBPWC_MF3);
    next_irq2_6 = !(smi_irq2 && mode == CBPWC_MODE_PAR_IRQ
                   && irq2_pin_sel == CBPWC_MF6);
    any_int = (|func_int) | (|csc_int) | (|system_mgmt_int_pending);
  end

  // ----------------------------------------------------------------
  // Serial interrupt packet
  // ----------------------------------------------------------------
  cbpwc_ser_e ser_st, next_ser_st;
  logic [4:0] slot, next_slot;
  logic [2:0] sub, next_sub;
  logic [CBPWC_SLOTS-1:0] slot_vec, snap, next_snap;
  logic       next_ser_o, next_ser_oe, ser_on;
  always_comb begin
    ser_on   = (mode == CBPWC_MODE_SER_IRQ) || (mode == CBPWC_MODE_SER_ALL);
    slot_vec = '0;
    slot_vec[CBPWC_SLOT_IRQ2] = smi_irq2;
    if (mode == CBPWC_MODE_SER_ALL) begin
      slot_vec[CBPWC_SLOT_INTA] = next_inta;
      slot_vec[CBPWC_SLOT_INTB] = next_intb;
    end
    next_ser_st = ser_st;
    next_slot   = slot;
    next_sub    = sub;
    next_snap   = snap;
    next_ser_o  = 1'b1;
    next_ser_oe = 1'b0;
    case (ser_st)
      CBPWC_SER_IDLE: begin
        if (ser_on && slot_vec != snap) begin
          next_ser_st = CBPWC_SER_START;
          next_snap   = slot_vec;
          next_sub    = '0;
        end
      end
      CBPWC_SER_START: begin
        next_ser_o  = 1'b0;
        next_ser_oe = 1'b1;
        next_sub    = sub + 3'h1;
        if (next_sub == CBPWC_START_LEN) begin
          next_ser_st = CBPWC_SER_SLOT;
          next_slot   = '0;
          next_sub    = '0;
        end
      end
      CBPWC_SER_SLOT: begin
        // Sample, recovery, turnaround per slot; low means asserted
        next_ser_o  = (sub == 3'h0) ? !snap[slot] : 1'b1;
        next_ser_oe = (sub != 3'h2);
        next_sub    = (sub == 3'h2) ? 3'h0 : sub + 3'h1;
        if (sub == 3'h2) begin
          next_slot = slot + 5'h1;
          if (slot == CBPWC_SLOT_LAST) begin
            next_ser_st = CBPWC_SER_STOP;
          end
        end
      end
      CBPWC_SER_STOP: begin
        next_ser_o  = 1'b0;
        next_ser_oe = 1'b1;
        next_sub    = sub + 3'h1;
        if (next_sub == CBPWC_STOP_LEN) begin
          next_ser_st = CBPWC_SER_IDLE;
        end
      end
      default: next_ser_st = CBPWC_SER_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Clock run, card clocks, card interface power, wake
  // ----------------------------------------------------------------
  logic [7:0] idle_cnt [2];
  logic [7:0] next_idle_cnt [2];
  logic [1:0] next_card_clock, next_tri, next_crst, next_ccr_oe, wake_pre;
  logic       deny_stop, restart, next_crun_oe, next_wake;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      next_idle_cnt[i] = card_activity[i] ? 8'h00
        : (idle_cnt[i] == CBPWC_IDLE_CYC ? idle_cnt[i] : idle_cnt[i] + 8'h01);
    end
    for (int i = 0; i < 2; i++) begin
      // Card clock runs until idle and the card releases clock run
      next_card_clock[i] = !card_is_16bit[i] && card_powered[i] &&
        !(idle_cnt[i] == CBPWC_IDLE_CYC && !card_clock_run_s[i]);
      next_ccr_oe[i] = card_clock_en[i] && idle_cnt[i] == CBPWC_IDLE_CYC;
      next_tri[i] = card_output_enable[i] | (auto_power_down[i] &
        card_is_16bit[i] & idle_cnt[i] == CBPWC_IDLE_CYC);
      next_crst[i] = card_output_enable[i];
    end
    deny_stop = hold_clock_request | res16_busy | cb_master_busy
              | pci_master_busy | any_int | (|card_clock_en);
    restart = (|card_int_request_s) | (|cardbus_int_s) | (|csts_s) | (|csc_event)
            | (|card_clock_run_s) | (|cardbus_bus_request_s) | (|dma_request_s);
    next_crun_oe = pci_clock_run_s ? (deny_stop | restart) : 1'b0;
    for (int i = 0; i < 2; i++) begin
      wake_pre[i] = (ring_enable[i] & card_is_16bit[i] & card_powered[i]
                     & ring_indicate_in[i])
                  | (status_change_mask[i] & !card_is_16bit[i]
                     & !card_powered[i] & card_status_change[i])
                  | csc_event[i];
    end
    next_wake = |wake_pre;
  end

  // Wake output is also kept combinational-free of the clock gate
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode                    <= CBPWC_MODE_RST;
      pmstate_f0              <= CBPWC_D0;
      pmstate_f1              <= CBPWC_D0;
      system_mgmt_int_pending <= '0;
      pend_d                  <= '0;
      int_pin_value_f0        <= CBPWC_PIN_A;
      int_pin_value_f1        <= CBPWC_PIN_B;
      csc_int                 <= '0;
      inta_mf0                <= 1'b0;
      intb_mf1                <= 1'b0;
      irq2_mf3_n              <= 1'b1;
      irq2_mf6_n              <= 1'b1;
      ser_st                  <= CBPWC_SER_IDLE;
      slot                    <= '0;
      sub                     <= '0;
      snap                    <= '0;
      serial_irq_line_o       <= 1'b1;
      serial_irq_line_oe      <= 1'b0;
      pci_clock_run_o         <= 1'b0;
      pci_clock_run_oe        <= 1'b0;
      idle_cnt[0]             <= '0;
      idle_cnt[1]             <= '0;
      card_clock_en           <= '0;
      card_clock_run_o        <= '0;
      card_clock_run_oe       <= '0;
      card_if_tristate        <= '0;
      card_reset              <= '0;
      core_reset_gated        <= 1'b0;
      core_clock_gate         <= 1'b0;
    end else if (clk_en) begin
      mode                    <= next_mode;
      pmstate_f0              <= next_pm0;
      pmstate_f1              <= next_pm1;
      system_mgmt_int_pending <= next_pend;
      pend_d                  <= next_pend_d;
      int_pin_value_f0        <= CBPWC_PIN_A;
      int_pin_value_f1        <= next_pin1;
      csc_int                 <= next_csc;
      inta_mf0                <= next_inta;
      intb_mf1                <= next_intb;
      irq2_mf3_n              <= next_irq2_3;
      irq2_mf6_n              <= next_irq2_6;
      ser_st                  <= next_ser_st;
      slot                    <= next_slot;
      sub                     <= next_sub;
      snap                    <= next_snap;
      serial_irq_line_o       <= next_ser_o;
      serial_irq_line_oe      <= next_ser_oe;
      pci_clock_run_o         <= 1'b0;
      pci_clock_run_oe        <= next_crun_oe;
      idle_cnt[0]             <= next_idle_cnt[0];
      idle_cnt[1]             <= next_idle_cnt[1];
      card_clock_en           <= next_card_clock;
      card_clock_run_o        <= '0;
      card_clock_run_oe       <= next_ccr_oe;
      card_if_tristate        <= next_tri;
      card_reset              <= next_crst;
      core_reset_gated        <= pci_reset_in_s & !susp_s;
      core_clock_gate         <= susp_s;
    end
  end

  // Wake path stays live with the clock gated or frozen
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ring_wake_out <= 1'b0;
    end else begin
      ring_wake_out <= next_wake;
    end
  end
endmodule

/* rtl/cbpwc_pkg.sv */
// Constants and types of the card bridge power and wake control block
package cbpwc_pkg;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] CBPWC_PIN_A = 8'h01;
  localparam logic [7:0] CBPWC_PIN_B = 8'h02;

  typedef enum logic [1:0] {
    CBPWC_MODE_PAR_PCI  = 2'h0,
    CBPWC_MODE_PAR_IRQ  = 2'h1,
    CBPWC_MODE_SER_IRQ  = 2'h2,
    CBPWC_MODE_SER_ALL  = 2'h3
  } cbpwc_mode_e;

  localparam cbpwc_mode_e CBPWC_MODE_RST = CBPWC_MODE_SER_ALL;

  typedef enum logic [1:0] {
    CBPWC_D0 = 2'h0,
    CBPWC_D1 = 2'h1,
    CBPWC_D2 = 2'h2,
    CBPWC_D3 = 2'h3
  } cbpwc_pstate_e;

  typedef enum logic [1:0] {
    CBPWC_SER_IDLE  = 2'h0,
    CBPWC_SER_START = 2'h1,
    CBPWC_SER_SLOT  = 2'h2,
    CBPWC_SER_STOP  = 2'h3
  } cbpwc_ser_e;

  // ----------------------------------------------------------------
  // Serial packet layout
  // ----------------------------------------------------------------
  localparam int unsigned CBPWC_SLOTS     = 20;
  localparam logic [4:0]  CBPWC_SLOT_LAST = 5'h13;
  localparam int unsigned CBPWC_SLOT_IRQ2 = 2;
  localparam int unsigned CBPWC_SLOT_INTA = 16;
  localparam int unsigned CBPWC_SLOT_INTB = 17;
  localparam logic [2:0]  CBPWC_START_LEN = 3'h4;
  localparam logic [2:0]  CBPWC_STOP_LEN  = 3'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CBPWC_CLK_MHZ  = 40;
  localparam int unsigned CBPWC_IDLE_NS  = 1000;
  localparam logic [7:0]  CBPWC_IDLE_CYC =
    8'((CBPWC_IDLE_NS * CBPWC_CLK_MHZ) / 1000);

  // Multifunction pin numbers able to carry a parallel IRQ2
  localparam logic [2:0] CBPWC_MF3 = 3'h3;
  localparam logic [2:0] CBPWC_MF6 = 3'h6;

endpackage

/* tb/cbpwc_core_properties.sv */
// Port checks for the card bridge power and wake control block
`timescale 1ns/1ps
module cbpwc_core_properties (
  // Clock and reset
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire logic                   clk_en,
  // Controls
  input wire logic                   interrupt_tie,
  input wire logic                   system_mgmt_int_enable,
  input wire logic                   hold_clock_request,
  input wire logic                   pci_clock_run_in,
  input wire logic [2:0]             irq2_pin_sel,
  input wire logic [1:0]             power_change_wr,
  input wire logic [1:0]             smi_pending_clr,
  input wire logic [1:0]             card_output_enable,
  // Outputs
  input wire logic [7:0]             int_pin_value_f0,
  input wire logic [7:0]             int_pin_value_f1,
  input wire cbpwc_pkg::cbpwc_mode_e mode,
  input wire logic [1:0]             system_mgmt_int_pending,
  input wire logic                   pci_clock_run_oe,
  input wire logic                   irq2_mf3_n,
  input wire logic [1:0]             card_if_tristate,
  input wire logic [1:0]             card_reset
);
  import cbpwc_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_mode_reset: assert property (
    $rose(rst_n) |-> mode == CBPWC_MODE_RST)
    else $error("Mode wrong after reset");
  a_pin_tied: assert property (
    clk_en && interrupt_tie |=> int_pin_value_f1 == CBPWC_PIN_A)
    else $error("Tied pin value wrong");
  a_pin_split: assert property (
    clk_en && !interrupt_tie |=> int_pin_value_f0 == CBPWC_PIN_A &&
      int_pin_value_f1 == CBPWC_PIN_B)
    else $error("Untied pin values wrong");
  a_pend_set: assert property (
    clk_en && system_mgmt_int_enable && power_change_wr[1]
      |=> system_mgmt_int_pending[1])
    else $error("Pending not set");
  a_pend_hold: assert property (
    clk_en && system_mgmt_int_pending[0] && !smi_pending_clr[0]
      |=> system_mgmt_int_pending[0])
    else $error("Pending lost");
  a_pend_gate: assert property (
    clk_en && !system_mgmt_int_enable && !system_mgmt_int_pending[0]
      |=> !system_mgmt_int_pending[0])
    else $error("Pending set while disabled");
  a_clock_deny: assert property (
    (clk_en && hold_clock_request && pci_clock_run_in) [*6]
      |=> pci_clock_run_oe)
    else $error("Clock stop not denied");
  a_coe_reset: assert property (
    clk_en && card_output_enable[0] |=> card_if_tristate[0] && card_reset[0])
    else $error("Output disable missing");
  a_irq2_pin: assert property (
    clk_en && irq2_pin_sel != CBPWC_MF3 |=> irq2_mf3_n)
    else $error("IRQ2 on unselected pin");
endmodule
bind cbpwc_core cbpwc_core_properties u_props (.*);

/* tb/cbpwc_host_model.sv */
// Host side model: serial interrupt receiver with a line pull-up
`timescale 1ns/1ps
module cbpwc_host_model (
  // Clock and reset
  input  wire logic   mclk,
  input  wire logic   rst_n,
  // Serial interrupt pin of the bridge
  input  wire logic   sirq_o,
  input  wire logic   sirq_oe,
  // Last decoded packet
  output logic [19:0] slots,
  output logic        pkt_done
);
  logic line;
  int   cnt;
  // Released line floats to the pull-up level
  assign line = sirq_oe ? sirq_o : 1'b1;
  always @(posedge mclk) begin
    pkt_done <= 1'b0;
    if (!rst_n) begin
      cnt <= 0;
      slots <= 20'h00000;
    end else if (cnt == 0) begin
      if (!line) cnt <= 1;
    end else if (cnt == 65) begin
      cnt <= 0;
      pkt_done <= 1'b1;
    end else begin
      cnt <= cnt + 1;
      // Low in the first cycle of a slot means asserted
      if (cnt >= 4 && cnt < 64 && (cnt - 4) % 3 == 0)
        slots[(cnt - 4) / 3] <= !line;
    end
  end
endmodule

/* tb/cbpwc_tb_top.sv */
// Self-checking bench for the card bridge power and wake control block
`timescale 1ns/1ps
module cbpwc_tb_top;
  import cbpwc_pkg::*;
  // ----------------------------------------------------------------
  // Design signals
  // ----------------------------------------------------------------
  logic mclk, rst_n, clk_en, interrupt_tie, mode_wr, system_mgmt_int_route;
  logic system_mgmt_int_enable, change_irq_mode, hold_clock_request;
  logic res16_busy, cb_master_busy, pci_master_busy, suspend, pci_reset_in;
  logic pci_clock_run_in, inta_mf0, intb_mf1, irq2_mf3_n, irq2_mf6_n;
  logic serial_irq_line_o, serial_irq_line_oe, pci_clock_run_o;
  logic pci_clock_run_oe, core_reset_gated, core_clock_gate, ring_wake_out;
  logic [2:0] irq2_pin_sel;
  logic [1:0] pmstate_wr, power_change_wr, smi_pending_clr, ring_enable;
  logic [1:0] card_output_enable, auto_power_down, status_change_mask;
  logic [1:0] card_is_16bit, card_powered, card_activity, csc_event;
  logic [1:0] func_int, card_int_request, cardbus_int, card_status_change;
  logic [1:0] ring_indicate_in, card_clock_run_in, cardbus_bus_request;
  logic [1:0] dma_request, system_mgmt_int_pending, csc_int, card_clock_en;
  logic [1:0] card_clock_run_o, card_clock_run_oe, card_if_tristate;
  logic [1:0] card_reset;
  logic [7:0] int_pin_value_f0, int_pin_value_f1;
  cbpwc_mode_e   mode_in, mode;
  cbpwc_pstate_e pmstate_in, pmstate_f0, pmstate_f1;
  logic [19:0] slots;
  logic        pkt_done;
  int          errors, comparisons;

  cbpwc_core uut (.*);
  cbpwc_host_model host (.mclk(mclk), .rst_n(rst_n),
    .sirq_o(serial_irq_line_o), .sirq_oe(serial_irq_line_oe),
    .slots(slots), .pkt_done(pkt_done));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic report_and_stop;
    $display("Counts: comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic t_pin;
    for (int m = 0; m < 8; m++) begin
      @(posedge mclk);
      mode_in <= cbpwc_mode_e'(m[1:0]);
      mode_wr <= 1'b1;
      @(posedge mclk);
      mode_wr <= 1'b0;
      interrupt_tie <= m[2];
      wt(2);
      chk(mode, m[1:0]);
      chk({int_pin_value_f1, int_pin_value_f0},
          m[2] ? 16'h0101 : 16'h0201);
    end
    @(posedge mclk) interrupt_tie <= 1'b0;
    $display("test pin values done");
  endtask

  task automatic t_smi;
    @(posedge mclk) power_change_wr <= 2'h3;
    @(posedge mclk) power_change_wr <= 2'h0;
    wt(1);
    chk(system_mgmt_int_pending, 2'h0);
    @(posedge mclk) system_mgmt_int_enable <= 1'b1;
    change_irq_mode <= 1'b1;
    power_change_wr <= 2'h1;
    smi_pending_clr <= 2'h1;
    @(posedge mclk) power_change_wr <= 2'h0;
    smi_pending_clr <= 2'h0;
    wt(3);
    chk({csc_int, system_mgmt_int_pending}, 4'h5);
    @(posedge mclk) smi_pending_clr <= 2'h1;
    @(posedge mclk) smi_pending_clr <= 2'h0;
    wt(3);
    chk({csc_int, system_mgmt_int_pending}, 4'h0);
    $display("test management interrupt done");
  endtask

  task automatic t_serial;
    int n;
    @(posedge mclk) system_mgmt_int_route <= 1'b1;
    func_int <= 2'h2;
    power_change_wr <= 2'h1;
    @(posedge mclk) power_change_wr <= 2'h0;
    n = 0;
    while (!pkt_done && n < 300) begin
      @(posedge mclk);
      n++;
    end
    if (n == 300) begin
      errors++;
      report_and_stop();
    end
    wt(150);
    chk(slots, 20'h20004);
    chk({inta_mf0, intb_mf1}, 2'h1);
    @(posedge mclk) interrupt_tie <= 1'b1;
    wt(2);
    chk({inta_mf0, intb_mf1}, 2'h2);
    @(posedge mclk) func_int <= 2'h0;
    interrupt_tie <= 1'b0;
    smi_pending_clr <= 2'h1;
    @(posedge mclk) smi_pending_clr <= 2'h0;
    system_mgmt_int_route <= 1'b0;
    wt(150);
    chk(slots, 20'h00000);
    @(posedge mclk) mode_in <= CBPWC_MODE_PAR_IRQ;
    mode_wr <= 1'b1;
    system_mgmt_int_route <= 1'b1;
    power_change_wr <= 2'h1;
    @(posedge mclk) mode_wr <= 1'b0;
    power_change_wr <= 2'h0;
    wt(3);
    chk({irq2_mf3_n, irq2_mf6_n}, 2'h1);
    @(posedge mclk) irq2_pin_sel <= CBPWC_MF6;
    wt(3);
    chk({irq2_mf3_n, irq2_mf6_n}, 2'h2);
    @(posedge mclk) irq2_pin_sel <= CBPWC_MF3;
    mode_in <= CBPWC_MODE_SER_ALL;
    mode_wr <= 1'b1;
    smi_pending_clr <= 2'h1;
    @(posedge mclk) mode_wr <= 1'b0;
    smi_pending_clr <= 2'h0;
    system_mgmt_int_route <= 1'b0;
    wt(4);
    $display("test serial packet done");
  endtask

  task automatic src(input int i, input logic v);
    case (i)
      0: hold_clock_request <= v;
      1: res16_busy <= v;
      2: cb_master_busy <= v;
      3: pci_master_busy <= v;
      4: card_int_request <= {1'b0, v};
      5: cardbus_int <= {v, 1'b0};
      6: card_clock_run_in <= {1'b0, v};
      7: cardbus_bus_request <= {v, 1'b0};
      8: card_status_change <= {1'b0, v};
      default: dma_request <= {v, 1'b0};
    endcase
  endtask

  task automatic t_clock;
    logic seen;
    @(posedge mclk) pci_clock_run_in <= 1'b1;
    wt(8);
    chk(pci_clock_run_oe, 1'b0);
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk) src(i, 1'b1);
      seen = 1'b0;
      repeat (12) begin
        @(negedge mclk);
        seen |= pci_clock_run_oe;
      end
      chk(seen, 1'b1);
      @(posedge mclk) src(i, 1'b0);
      wt(60);
      chk({pci_clock_run_oe, card_clock_en}, 3'h0);
    end
    @(posedge mclk) pci_clock_run_in <= 1'b0;
    $display("test clock run done");
  endtask

  task automatic t_card16;
    @(posedge mclk) card_output_enable <= 2'h1;
    wt(2);
    chk({card_if_tristate, card_reset}, 4'h5);
    @(posedge mclk) card_output_enable <= 2'h0;
    auto_power_down <= 2'h2;
    card_is_16bit <= 2'h2;
    wt(50);
    chk({card_if_tristate, card_reset}, 4'h8);
    @(posedge mclk) card_activity <= 2'h2;
    wt(3);
    chk(card_if_tristate, 2'h0);
    @(posedge mclk) card_activity <= 2'h0;
    auto_power_down <= 2'h0;
    card_is_16bit <= 2'h0;
    suspend <= 1'b1;
    pci_reset_in <= 1'b1;
    wt(6);
    chk({core_reset_gated, core_clock_gate}, 2'h1);
    @(posedge mclk) suspend <= 1'b0;
    wt(6);
    chk({core_reset_gated, core_clock_gate}, 2'h2);
    @(posedge mclk) pci_reset_in <= 1'b0;
    $display("test card power done");
  endtask

  task automatic t_wake;
    @(posedge mclk) card_status_change <= 2'h2;
    wt(6);
    chk(ring_wake_out, 1'b0);
    @(posedge mclk) card_status_change <= 2'h0;
    clk_en <= 1'b0;
    {card_is_16bit, card_powered, ring_indicate_in} <= 6'h15;
    wt(6);
    chk(ring_wake_out, 1'b0);
    @(posedge mclk) ring_enable <= 2'h1;
    wt(6);
    chk(ring_wake_out, 1'b1);
    @(posedge mclk) {card_is_16bit, card_powered, ring_indicate_in} <= 6'h0;
    ring_enable <= 2'h0;
    clk_en <= 1'b1;
    status_change_mask <= 2'h2;
    card_status_change <= 2'h2;
    wt(8);
    chk(ring_wake_out, 1'b1);
    @(posedge mclk) card_status_change <= 2'h0;
    $display("test wake output done");
  endtask

  task automatic t_pm;
    for (int k = 7; k >= 0; k--) begin
      @(posedge mclk) pmstate_in <= cbpwc_pstate_e'(k[1:0]);
      pmstate_wr <= k[2] ? 2'h2 : 2'h1;
      @(posedge mclk) pmstate_wr <= 2'h0;
      wt(1);
      chk(k[2] ? pmstate_f1 : pmstate_f0, k[1:0]);
    end
    $display("test power states done");
  endtask

  initial begin
    errors = 0;
    comparisons = 0;
    {rst_n, interrupt_tie, mode_wr, system_mgmt_int_route, suspend} = '0;
    {system_mgmt_int_enable, change_irq_mode, hold_clock_request} = '0;
    {res16_busy, cb_master_busy, pci_master_busy, pci_reset_in} = '0;
    {pci_clock_run_in, pmstate_wr, power_change_wr, smi_pending_clr} = '0;
    {card_output_enable, auto_power_down, ring_enable} = '0;
    {status_change_mask, card_is_16bit, card_powered, card_activity} = '0;
    {csc_event, func_int, card_int_request, cardbus_int} = '0;
    {card_status_change, ring_indicate_in, card_clock_run_in} = '0;
    {cardbus_bus_request, dma_request} = '0;
    clk_en = 1'b1;
    irq2_pin_sel = CBPWC_MF3;
    mode_in = CBPWC_MODE_SER_ALL;
    pmstate_in = CBPWC_D0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    wt(1);
    chk({mode, pmstate_f0, pmstate_f1}, 6'h30);
    chk({system_mgmt_int_pending, serial_irq_line_oe}, 3'h0);
    t_pin();
    t_smi();
    t_serial();
    t_clock();
    t_card16();
    t_wake();
    t_pm();
    report_and_stop();
  end
endmodule
